// File: asp_port.v
// serial host port of the converter: control register, result reads, ready flag
`timescale 1ns/100ps
`include "asp_defs.vh"
module asp_port #(
  parameter WIDTH      = `ASP_WORD_BITS,
  parameter FIFO_DEPTH = `ASP_FIFO_DEPTH,
  parameter FIFO_AW    = `ASP_FIFO_AW
) (
  // clock and reset
  clock,
  resetn,
  // frame pins from the host
  receive_frame_sync_n,
  transmit_frame_sync_n,
  register_select,
  // serial clock pin, two-way
  serial_clock_in,
  serial_clock_out,
  serial_clock_oe,
  // serial data pin, two-way
  serial_data_in,
  serial_data_out,
  serial_data_oe,
  // ready flag pin
  result_ready_n,
  // converter core side
  self_clocking,
  bipolar,
  result_valid,
  result_ready,
  result_data,
  cal_done,
  control_word
);
  input  wire             clock;
  input  wire             resetn;
  input  wire             receive_frame_sync_n;
  input  wire             transmit_frame_sync_n;
  input  wire             register_select;
  input  wire             serial_clock_in;
  output reg              serial_clock_out;
  output reg              serial_clock_oe;
  input  wire             serial_data_in;
  output reg              serial_data_out;
  output reg              serial_data_oe;
  output reg              result_ready_n;
  input  wire             self_clocking;
  input  wire             bipolar;
  input  wire             result_valid;
  output wire             result_ready;
  input  wire [WIDTH-1:0] result_data;
  input  wire             cal_done;
  output reg  [WIDTH-1:0] control_word;

  localparam ST_IDLE  = 4'b0001;
  localparam ST_WRITE = 4'b0010;
  localparam ST_READ  = 4'b0100;
  localparam ST_HOLD  = 4'b1000;

  // pin inputs pass two flops before use
  wire rfs_n;
  wire tfs_n;
  wire sel;
  wire sck;
  wire sdi;
  asp_sync #(.RESET_VALUE(1'b1)) u_rfs (.clock(clock), .resetn(resetn), .din(receive_frame_sync_n),
    .dout(rfs_n));
  asp_sync #(.RESET_VALUE(1'b1)) u_tfs (.clock(clock), .resetn(resetn), .din(transmit_frame_sync_n),
    .dout(tfs_n));
  asp_sync #(.RESET_VALUE(1'b0)) u_sel (.clock(clock), .resetn(resetn), .din(register_select),
    .dout(sel));
  asp_sync #(.RESET_VALUE(1'b0)) u_sck (.clock(clock), .resetn(resetn), .din(serial_clock_in),
    .dout(sck));
  asp_sync #(.RESET_VALUE(1'b0)) u_sdi (.clock(clock), .resetn(resetn), .din(serial_data_in),
    .dout(sdi));

  // result words queue here until the host reads them
  wire             fifo_valid;
  reg              fifo_pop;
  wire [WIDTH-1:0] fifo_data;
  asp_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // offset binary flips the sign bit of the two's complement result
  function [WIDTH-1:0] code_word;
    input [WIDTH-1:0] raw;
    input             bip;
    begin
      code_word = bip ? (raw ^ `ASP_MIDSCALE) : raw;
    end
  endfunction

  reg  [3:0]             state;
  reg  [WIDTH-1:0]       shreg;
  reg  [`ASP_CNT_BITS-1:0] bitcnt;
  reg                    sck_prev;
  reg                    gen_clk;
  reg  [7:0]             div;
  reg                    read_data;
  reg                    cal_flag;
  wire                   clk_int;
  wire                   rise;
  wire                   fall;

  // in self-clocking mode our own divided clock times the read bits, and a write frame takes no bits
  assign clk_int = self_clocking ? gen_clk : sck;
  assign rise    = clk_int && !sck_prev;
  assign fall    = !clk_int && sck_prev;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state            <= ST_IDLE;
      shreg            <= `ASP_CTRL_RESET;
      bitcnt           <= `ASP_CNT_ZERO;
      sck_prev         <= 1'b0;
      gen_clk          <= 1'b0;
      div              <= `ASP_SCLK_ZERO;
      read_data        <= 1'b0;
      cal_flag         <= 1'b0;
      control_word     <= `ASP_CTRL_RESET;
      serial_clock_out <= 1'b0;
      serial_clock_oe  <= 1'b0;
      serial_data_out  <= 1'b0;
      serial_data_oe   <= 1'b0;
      result_ready_n   <= 1'b1;
      fifo_pop         <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      sck_prev <= clk_int;
      // calibration end holds the flag low until a result read takes it
      if (cal_done) begin
        cal_flag <= 1'b1;
      end
      // divider only runs while we own the clock in a read frame
      if (self_clocking && state == ST_READ) begin
        if (div == `ASP_SCLK_HALF) begin
          div     <= `ASP_SCLK_ZERO;
          gen_clk <= !gen_clk;
        end else begin
          div <= div + `ASP_SCLK_ONE;
        end
      end else begin
        div     <= `ASP_SCLK_ZERO;
        gen_clk <= 1'b0;
      end
      serial_clock_out <= gen_clk;
      case (state)
        ST_IDLE: begin
          serial_data_oe  <= 1'b0;
          serial_clock_oe <= 1'b0;
          bitcnt          <= `ASP_CNT_ZERO;
          // ready falls for a queued result or finished calibration
          result_ready_n  <= !(fifo_valid || cal_flag);
          if (!tfs_n) begin
            state <= ST_WRITE;
          end else if (!rfs_n) begin
            if (!sel) begin
              shreg     <= control_word;
              read_data <= 1'b0;
              state     <= ST_READ;
            end else if (!result_ready_n) begin
              // results go out only while ready is low
              shreg     <= fifo_valid ? code_word(fifo_data, bipolar) : `ASP_CTRL_RESET;
              read_data <= 1'b1;
              state     <= ST_READ;
            end
          end
        end
        ST_WRITE: begin
          if (rise && bitcnt != `ASP_CNT_FULL) begin
            shreg  <= {shreg[WIDTH-2:0], sdi};
            bitcnt <= bitcnt + `ASP_CNT_ONE;
          end
          if (tfs_n) begin
            // only a full word reaches the register, extra pulses were dropped
            if (bitcnt == `ASP_CNT_FULL && !sel) begin
              control_word <= shreg;
            end
            state <= ST_IDLE;
          end
        end
        ST_READ: begin
          serial_data_oe  <= 1'b1;
          serial_clock_oe <= self_clocking;
          serial_data_out <= shreg[`ASP_MSB];
          if (fall) begin
            shreg  <= {shreg[WIDTH-2:0], 1'b0};
            bitcnt <= bitcnt + `ASP_CNT_ONE;
            if (bitcnt == `ASP_LAST_BIT) begin
              if (read_data) begin
                result_ready_n <= 1'b1;
                // a calibration end in this very cycle outlives the clear
                cal_flag       <= cal_done;
                fifo_pop       <= fifo_valid;
              end
              state <= ST_HOLD;
            end
          end
          if (rfs_n) begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // word done; release the lines and wait for the frame to close
          serial_data_oe  <= 1'b0;
          serial_clock_oe <= 1'b0;
          if (rfs_n) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: asp_defs.vh
// constants for the converter serial port
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
`define ASP_WORD_BITS   24
`define ASP_CNT_BITS    5
`define ASP_LAST_BIT    5'h17
`define ASP_CTRL_RESET  24'h000000
`define ASP_CNT_ZERO    5'h00
`define ASP_CNT_ONE     5'h01
`define ASP_CNT_FULL    5'h18
`define ASP_SCLK_HALF   8'h0C
`define ASP_SCLK_ZERO   8'h00
`define ASP_SCLK_ONE    8'h01
`define ASP_MSB         23
`define ASP_MIDSCALE    24'h800000
`define ASP_FIFO_DEPTH  8
`define ASP_FIFO_AW     3
`endif

// File: asp_sync.v
// two flop synchroniser for one level
`timescale 1ns/100ps
`include "asp_defs.vh"
module asp_sync #(
  parameter RESET_VALUE = 1'b1
) (
  // clock and reset
  input  wire clock,
  input  wire resetn,
  // level in and out
  input  wire din,
  output reg  dout
);
  reg stage;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage <= RESET_VALUE;
      dout  <= RESET_VALUE;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// File: asp_fifo.v
// result word fifo with valid and ready on both sides
`timescale 1ns/100ps
`include "asp_defs.vh"
module asp_fifo #(
  parameter WIDTH = `ASP_WORD_BITS,
  parameter DEPTH = `ASP_FIFO_DEPTH,
  parameter AW    = `ASP_FIFO_AW
) (
  // clock and reset
  input  wire             clock,
  input  wire             resetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             full_n;
  wire            push;
  wire            pop;
  // ready comes from a flop so the core sees no combinational path back
  assign in_ready  = full_n;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      full_n <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
      // full flag follows the count that this edge leaves behind
      if (push && !pop) begin
        full_n <= (count != DEPTH[AW:0] - 1'b1);
      end else if (pop && !push) begin
        full_n <= 1'b1;
      end
    end
  end
endmodule

// File: asp_port_checker.sv
// assertions on the converter serial port pins
`timescale 1ns/100ps
module asp_port_checker #(
  parameter WIDTH = 24
) (
  // clock and reset
  input logic             clock,
  input logic             resetn,
  // frame pins
  input logic             receive_frame_sync_n,
  input logic             transmit_frame_sync_n,
  input logic             register_select,
  // serial pins
  input logic             serial_clock_in,
  input logic             serial_clock_out,
  input logic             serial_clock_oe,
  input logic             serial_data_in,
  input logic             serial_data_out,
  input logic             serial_data_oe,
  input logic             result_ready_n,
  // core side
  input logic             self_clocking,
  input logic             bipolar,
  input logic             result_valid,
  input logic             result_ready,
  input logic             cal_done,
  input logic [WIDTH-1:0] result_data,
  input logic [WIDTH-1:0] control_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_clk_self; serial_clock_oe |-> self_clocking; endproperty
  a_clk_self: assert property (p_clk_self) else $error("clock driven in external mode");
  property p_oe_frame; $rose(serial_data_oe) |-> !$past(receive_frame_sync_n, 2); endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("data driven without read frame");
  property p_rdy_fall; result_valid && result_ready && result_ready_n && receive_frame_sync_n |-> ##[1:6] !result_ready_n;
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready flag missed new word");
  property p_rdy_rise; $rose(result_ready_n) |-> !$past(receive_frame_sync_n, 3) && $past(register_select, 3); endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready flag rose without result read");
  property p_cal; cal_done && result_ready_n && receive_frame_sync_n |-> ##[1:6] !result_ready_n; endproperty
  a_cal: assert property (p_cal) else $error("ready flag missed calibration end");
  property p_gate; $rose(serial_data_oe) && register_select |-> !result_ready_n; endproperty
  a_gate: assert property (p_gate) else $error("result driven while flag high");
  property p_ctrl_frame; !$stable(control_word) |-> transmit_frame_sync_n && !$past(register_select, 4); endproperty
  a_ctrl_frame: assert property (p_ctrl_frame) else $error("control changed inside frame");
  property p_no_oe_wr; !transmit_frame_sync_n && $past(receive_frame_sync_n, 3) |-> !$rose(serial_data_oe); endproperty
  a_no_oe_wr: assert property (p_no_oe_wr) else $error("data driven during write");
  c_ctrl: cover property (!$stable(control_word));
  c_self: cover property ($rose(serial_clock_oe));
  c_rdy: cover property ($rose(result_ready_n));
endmodule
bind asp_port asp_port_checker #(.WIDTH(WIDTH)) asp_port_checker_i (.*);

// File: asp_host.sv
// host model on the far side of the serial port
`timescale 1ns/100ps
module asp_host (
  // frame pins
  output logic receive_frame_sync_n,
  output logic transmit_frame_sync_n,
  output logic register_select,
  // resolved two-way pins
  output logic serial_clock_in,
  output logic serial_data_in,
  // device drive
  input  logic serial_clock_out,
  input  logic serial_clock_oe,
  input  logic serial_data_out,
  input  logic serial_data_oe,
  input  logic self_clocking
);
  logic hclk = 0, hd = 0, hoe = 0, last = 0;
  initial begin
    receive_frame_sync_n = 1;
    transmit_frame_sync_n = 1;
    register_select = 0;
  end
  // a released line shows the inverse of its last bit, so a stale bit never reads as valid
  always @* serial_data_in = serial_data_oe ? serial_data_out : hoe ? hd : ~last;
  always @(serial_data_in) if (serial_data_oe | hoe) last = serial_data_in;
  // host clock rests low outside frames
  always @* serial_clock_in = serial_clock_oe ? serial_clock_out : hclk;
  task write_word(input logic sel, input logic [23:0] w, input int n);
    register_select = sel;
    transmit_frame_sync_n = 0;
    hoe = 1;
    #100;
    for (int i = 0; i < n; i++) begin
      hd = w[23 - i % 24];
      #62.5 hclk = 1;
      #62.5 hclk = 0;
    end
    #100 transmit_frame_sync_n = 1;
    #20 hoe = 0;
    #200;
  endtask
  task read_word(input logic sel, output logic [23:0] w);
    register_select = sel;
    receive_frame_sync_n = 0;
    // the device's own first clock edge comes before 100 ns, so only wait when we clock
    if (!self_clocking) #100;
    for (int i = 0; i < 24; i++) begin
      if (self_clocking) @(posedge serial_clock_out);
      else #62.5 hclk = 1;
      w = {w[22:0], serial_data_in};
      if (!self_clocking) #62.5 hclk = 0;
    end
    #100 receive_frame_sync_n = 1;
    #200;
  endtask
endmodule

// File: asp_port_tb.sv
// testbench for the converter serial port
`timescale 1ns/100ps
module asp_port_tb;
  logic        clock = 0, resetn = 0, self_clocking = 0, bipolar = 0, result_valid = 0, cal_done = 0, seen_oe;
  logic [23:0] result_data = 0, control_word, w;
  logic        receive_frame_sync_n, transmit_frame_sync_n, register_select, serial_clock_in, serial_data_in;
  logic        serial_clock_out, serial_clock_oe, serial_data_out, serial_data_oe, result_ready_n, result_ready;
  int          error_cnt = 0, checks = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) if (serial_data_oe) seen_oe <= 1;
  asp_port asp_port_i (.*);
  asp_host asp_host_i (.*);
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task t_ctrl;
    asp_host_i.write_word(0, 24'h5A3C96, 24);
    chk("control", 24'h5A3C96, control_word);
    asp_host_i.read_word(0, w);
    chk("control read", 24'h5A3C96, w);
    @(posedge clock);
    #1 self_clocking = 1;
    asp_host_i.read_word(0, w);
    chk("self clock read", 24'h5A3C96, w);
    @(posedge clock);
    #1 self_clocking = 0;
    $display("test ctrl ended");
  endtask
  task t_frames;
    asp_host_i.write_word(0, 24'h123456, 12);
    chk("partial write", 24'h5A3C96, control_word);
    asp_host_i.write_word(0, 24'hC0FFEE, 30);
    chk("long write", 24'hC0FFEE, control_word);
    asp_host_i.write_word(1, 24'h111111, 24);
    chk("select high write", 24'hC0FFEE, control_word);
    $display("test frames ended");
  endtask
  task t_fifo;
    int n;
    n = 0;
    @(posedge clock);
    #1 result_valid = 1;
    while (result_ready === 1 && n < 12) begin
      result_data = 24'h0F0F00 + 24'(n);
      @(posedge clock);
      #1 n++;
    end
    result_valid = 0;
    chk("fill count", 24'h000008, 24'(n));
    chk("ready flag", 24'h000000, 24'(result_ready_n));
    for (int k = 0; k < 8; k++) begin
      asp_host_i.read_word(1, w);
      chk("result", 24'h0F0F00 + 24'(k), w);
    end
    chk("ready flag", 24'h000001, 24'(result_ready_n));
    $display("test fifo ended");
  endtask
  task t_code;
    @(posedge clock);
    #1 bipolar = 1;
    result_data = 24'h000001;
    result_valid = 1;
    @(posedge clock);
    #1 result_valid = 0;
    self_clocking = 1;
    asp_host_i.read_word(1, w);
    chk("bipolar result", 24'h800001, w);
    @(posedge clock);
    #1 self_clocking = 0;
    bipolar = 0;
    $display("test code ended");
  endtask
  task t_cal;
    @(posedge clock);
    #1 cal_done = 1;
    @(posedge clock);
    #1 cal_done = 0;
    repeat (8) @(posedge clock);
    chk("cal flag", 24'h000000, 24'(result_ready_n));
    asp_host_i.read_word(1, w);
    chk("cal word", 24'h000000, w);
    chk("cal flag", 24'h000001, 24'(result_ready_n));
    seen_oe = 0;
    asp_host_i.read_word(1, w);
    chk("data drive", 24'h000000, 24'(seen_oe));
    $display("test cal ended");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end
  initial begin
    #8.5 resetn = 1;
    repeat (4) @(posedge clock);
    t_ctrl;
    t_frames;
    t_fifo;
    t_code;
    t_cal;
    complete_run;
  end
endmodule
